// File: verilog/sar_adc_pkg.sv
// Package with register map, field layout and timing constants of the converter control.
package sar_adc_pkg;
    localparam int RESULT_BITS = 10;
    localparam int CHAN_COUNT = 16;
    localparam int CHAN_BITS = 4;
    // Register byte offsets on the AXI4-Lite bus.
    localparam logic [3:0] ADDR_CSR = 4'h0;
    localparam logic [3:0] ADDR_HIGH = 4'h4;
    localparam logic [3:0] ADDR_LOW = 4'h8;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'hc;
    // Interrupt enable and clear registers share the status layout.
    localparam logic [4:0] ADDR_IRQ_ENABLE = 5'h10;
    localparam logic [4:0] ADDR_IRQ_CLEAR = 5'h14;
    // Control/status register fields.
    localparam int CSR_EOC = 7;
    localparam int CSR_SPEED = 6;
    localparam int CSR_ON = 5;
    localparam int CSR_CH_LSB = 0;
    localparam logic [7:0] CSR_RESET = 8'h00;
    localparam logic [7:0] RESULT_HIGH_RESET = 8'h00;
    localparam logic [1:0] RESULT_LOW_RESET = 2'h0;
    // Interrupt status bits: end of conversion, aborted conversion.
    localparam int IRQ_BITS = 2;
    localparam int IRQ_EOC = 0;
    localparam int IRQ_ABORT = 1;
    // Converter clock: cpu clock divided by 4 (speed 0) or 2 (speed 1).
    localparam logic [1:0] DIV_SLOW = 2'h3;
    localparam logic [1:0] DIV_FAST = 2'h1;
    // Last sample count; the sample phase lasts SAMPLE_STEPS + 1 converter clock steps.
    localparam logic [3:0] SAMPLE_STEPS = 4'h3;
    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;
    typedef enum {ST_OFF, ST_SAMPLE, ST_CONVERT} seq_state_t;
endpackage

// File: verilog/sar_step_if.sv
// Interface between the control logic and the successive-approximation step engine.
`timescale 1ns/1ps
interface sar_step_if;
    logic start;
    logic abort;
    logic step;
    logic comp_above;
    logic [9:0] trial;
    logic [9:0] result;
    logic done;
    modport ctrl (output start, output abort, output step, output comp_above,
        input trial, input result, input done);
    modport engine (input start, input abort, input step, input comp_above,
        output trial, output result, output done);
endinterface

// File: verilog/sar_step_engine.sv
// Successive-approximation search, one bit per step pulse from the control logic.
`timescale 1ns/1ps
module sar_step_engine #(
    parameter int WIDTH = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Control side
    sar_step_if.engine sar
);
    import sar_adc_pkg::*;

    logic [WIDTH-1:0] bit_mask;
    logic [WIDTH-1:0] kept;
    logic busy;

    // Present trial level is the kept bits plus the bit under test.
    assign sar.trial = kept | bit_mask;

    always_ff @(posedge aclk) begin
        if (!aresetn || sar.abort) begin
            bit_mask <= '0;
            kept <= '0;
            busy <= 1'b0;
        end else if (sar.start) begin
            bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
            kept <= '0;
            busy <= 1'b1;
        end else if (busy && sar.step) begin
            // A bit is kept when the input is not below the trial level.
            if (sar.comp_above) begin
                kept <= kept | bit_mask;
            end
            bit_mask <= bit_mask >> 1;
            if (bit_mask[0]) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || sar.abort || sar.start) begin
            sar.done <= 1'b0;
        end else begin
            sar.done <= busy && sar.step && bit_mask[0];
        end
    end

    // Final result includes the decision on the last bit.
    assign sar.result = (sar.comp_above) ? (kept | bit_mask) : kept;
endmodule

// File: verilog/sar_adc_control.sv
// Control logic of a 10-bit successive-approximation converter with AXI4-Lite registers.
//
// Notes on behaviour
// - Each conversion yields a 10-bit result by successive approximation after sampling.
// - Any of 16 analog inputs is routed through the multiplexer to sampling.
// - Input above high reference gives all-ones result, no overflow flag.
// - Input below low reference gives zero in both result registers.
// - Setting the on bit starts continuous back-to-back conversions while it stays set.
// - Each finished conversion loads the result registers and sets end-of-conversion.
// - End-of-conversion clears on a high result read or any control write.
// - Results are never locked; each conversion overwrites both result registers.
// - Changing channel mid-conversion aborts it, clears the flag, restarts new channel.
// - Analog pins stay readable as digital inputs; software leaves them plain inputs.
// - High result holds bits 9..2; low holds bits 1..0, upper bits zero.
// - Clearing the on bit disables the converter and stops conversion.
// - Channel code maps directly to input index 0 through 15.
`timescale 1ns/1ps
module sar_adc_control #(
    parameter int CHANNELS = sar_adc_pkg::CHAN_COUNT
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog front end
    output logic [sar_adc_pkg::CHAN_BITS-1:0] analog_input_pin_select,
    output logic front_end_enable,
    output logic sample_hold,
    output logic [sar_adc_pkg::RESULT_BITS-1:0] dac_trial,
    input wire logic comparator_above,
    // Digital view of the analog pins
    input wire logic [CHANNELS-1:0] analog_input_pin,
    output logic [CHANNELS-1:0] analog_input_pin_level,
    // Interrupt
    output logic irq
);
    import sar_adc_pkg::*;

    sar_step_if sar ();

    seq_state_t state;
    logic [7:0] conv_ctrl_status_reg;
    logic eoc_flag;
    logic [6:0] csr_fields;
    logic [1:0] settle;
    logic [7:0] result_high_reg;
    logic [1:0] result_low_reg;
    logic [IRQ_BITS-1:0] irq_status;
    logic [IRQ_BITS-1:0] irq_enable;
    logic [1:0] div_count;
    logic conv_tick;
    logic [3:0] sample_count;
    logic comp_meta;
    logic comp_sync;
    logic [CHANNELS-1:0] pin_meta;
    logic [CHANNELS-1:0] pin_sync;

    // Bus bookkeeping.
    logic aw_held;
    logic w_held;
    logic [31:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic write_go;
    logic read_go;
    logic csr_write;
    logic high_read;
    logic [7:0] next_csr;
    logic channel_change;
    logic conv_on;
    logic eoc_set;
    logic abort_event;

    // Converter clock divider.
    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_on) begin
            div_count <= '0;
        end else if (conv_tick) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 2'h1;
        end
    end
    assign conv_tick = conv_on && (div_count ==
        (conv_ctrl_status_reg[CSR_SPEED] ? DIV_FAST : DIV_SLOW));

    // Comparator and pin levels come from outside the clock domain.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_meta <= 1'b0;
            comp_sync <= 1'b0;
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            comp_meta <= comparator_above;
            comp_sync <= comp_meta;
            pin_meta <= analog_input_pin;
            pin_sync <= pin_meta;
        end
    end
    assign analog_input_pin_level = pin_sync;

    // AXI4-Lite write channel: address and data taken in either order.
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign write_go = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (write_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr[31:5] == '0 && aw_addr[1:0] == 2'h0 &&
                    (aw_addr[4:0] == {1'b0, ADDR_CSR} ||
                     aw_addr[4:0] == ADDR_IRQ_ENABLE ||
                     aw_addr[4:0] == ADDR_IRQ_CLEAR)) ? AXI_OKAY : AXI_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign csr_write = write_go && aw_addr[31:0] == {28'h0, ADDR_CSR} && w_strb[0];
    // Reserved bit 4 and the flag are not writable.
    assign next_csr = {conv_ctrl_status_reg[CSR_EOC], w_data[CSR_SPEED], w_data[CSR_ON],
        1'b0, w_data[3:0]};
    assign channel_change = csr_write &&
        next_csr[3:0] != conv_ctrl_status_reg[3:0] && next_csr[CSR_ON];

    // AXI4-Lite read channel.
    assign s_axi_arready = !s_axi_rvalid;
    assign read_go = s_axi_arvalid && s_axi_arready;
    assign high_read = read_go && s_axi_araddr == {28'h0, ADDR_HIGH};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= AXI_OKAY;
        end else if (read_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= AXI_OKAY;
            case (s_axi_araddr)
                {28'h0, ADDR_CSR}: s_axi_rdata <= {24'h0, conv_ctrl_status_reg};
                {28'h0, ADDR_HIGH}: s_axi_rdata <= {24'h0, result_high_reg};
                {28'h0, ADDR_LOW}: s_axi_rdata <= {30'h0, result_low_reg};
                {28'h0, ADDR_IRQ_STATUS}: s_axi_rdata <= {30'h0, irq_status};
                {27'h0, ADDR_IRQ_ENABLE}: s_axi_rdata <= {30'h0, irq_enable};
                {27'h0, ADDR_IRQ_CLEAR}: s_axi_rdata <= '0;
                default: begin
                    s_axi_rdata <= '0;
                    s_axi_rresp <= AXI_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Control/status register fields held by software.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            csr_fields <= CSR_RESET[6:0];
        end else if (csr_write) begin
            csr_fields <= next_csr[6:0];
        end
    end
    assign conv_ctrl_status_reg = {eoc_flag, csr_fields};
    assign conv_on = conv_ctrl_status_reg[CSR_ON];

    // End-of-conversion flag: a completing conversion wins over a clearing access.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            eoc_flag <= CSR_RESET[CSR_EOC];
        end else if (eoc_set) begin
            eoc_flag <= 1'b1;
        end else if (high_read || csr_write) begin
            eoc_flag <= 1'b0;
        end
    end

    // Sequencer: sample, then resolve, then start over while on.
    assign abort_event = channel_change && state == ST_CONVERT;
    always_ff @(posedge aclk) begin
        if (!aresetn || !conv_on) begin
            state <= ST_OFF;
            sample_count <= '0;
        end else if (channel_change) begin
            state <= ST_SAMPLE;
            sample_count <= '0;
        end else begin
            case (state)
                ST_OFF: begin
                    state <= ST_SAMPLE;
                    sample_count <= '0;
                end
                ST_SAMPLE: begin
                    if (conv_tick) begin
                        if (sample_count == SAMPLE_STEPS) begin
                            state <= ST_CONVERT;
                        end else begin
                            sample_count <= sample_count + 4'h1;
                        end
                    end
                end
                ST_CONVERT: begin
                    if (sar.done) begin
                        state <= ST_SAMPLE;
                        sample_count <= '0;
                    end
                end
                default: state <= ST_OFF;
            endcase
        end
    end

    assign sar.start = state == ST_SAMPLE && conv_tick && sample_count == SAMPLE_STEPS &&
        !channel_change;
    assign sar.abort = !conv_on || channel_change;
    // The trial output register and the comparator synchroniser add three cycles, so a
    // step waits for that settling; at the fast clock this costs every other tick.
    always_ff @(posedge aclk) begin
        if (!aresetn || sar.start || sar.step) begin
            settle <= 2'h0;
        end else if (settle != 2'h3) begin
            settle <= settle + 2'h1;
        end
    end
    assign sar.step = conv_tick && state == ST_CONVERT && settle == 2'h3;
    assign sar.comp_above = comp_sync;
    assign eoc_set = sar.done && !channel_change && conv_on;

    sar_step_engine #(
        .WIDTH(RESULT_BITS)
    ) engine (
        .aclk(aclk),
        .aresetn(aresetn),
        .sar(sar)
    );

    // Result registers are overwritten by every completed conversion.
    // A saturated comparator yields all ones or all zeros naturally.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result_high_reg <= RESULT_HIGH_RESET;
            result_low_reg <= RESULT_LOW_RESET;
        end else if (eoc_set) begin
            result_high_reg <= sar.result[9:2];
            result_low_reg <= sar.result[1:0];
        end
    end

    // The engine decides the last bit on the step that raises done, so keep its result.
    // Front end drive.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            analog_input_pin_select <= '0;
            front_end_enable <= 1'b0;
            sample_hold <= 1'b0;
            dac_trial <= '0;
        end else begin
            analog_input_pin_select <= conv_ctrl_status_reg[3:0];
            front_end_enable <= conv_on;
            sample_hold <= state == ST_SAMPLE;
            dac_trial <= sar.trial;
        end
    end

    // Interrupt status: set wins over clear.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_status <= '0;
            irq_enable <= '0;
        end else begin
            irq_status <= (irq_status & ~((write_go && aw_addr == {27'h0, ADDR_IRQ_CLEAR})
                ? w_data[IRQ_BITS-1:0] : '0)) | {abort_event, eoc_set};
            if (write_go && aw_addr == {27'h0, ADDR_IRQ_ENABLE}) begin
                irq_enable <= w_data[IRQ_BITS-1:0];
            end
        end
    end
    assign irq = |(irq_status & irq_enable);
endmodule

// File: verification/sar_adc_control_checker.sv
// Port-level assertions for the converter control block.
`timescale 1ns/1ps
module sar_adc_control_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Read channels and write response
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    // Front end and interrupt
    input wire logic front_end_enable,
    input wire logic sample_hold,
    input wire logic [sar_adc_pkg::RESULT_BITS-1:0] dac_trial,
    input wire logic irq
);
    import sar_adc_pkg::*;
    default clocking dflt @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [9:0] prev_trial;
    logic [9:0] prev_low;
    logic [2:0] prev_sh;
    always_ff @(posedge aclk) begin
        prev_trial <= dac_trial;
        prev_sh <= {prev_sh[1:0], sample_hold};
    end
    // Lowest set bit of the previous trial marks the bit that was being tried.
    assign prev_low = prev_trial & (~prev_trial + 10'h001);
    sequence s_read_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_convert_start;
        front_end_enable && $fell(sample_hold);
    endsequence
    property p_reset_clear;
        $rose(aresetn) |-> !front_end_enable && !sample_hold && !irq
            && !s_axi_bvalid && !s_axi_rvalid;
    endproperty
    property p_sample_needs_on;
        sample_hold |-> front_end_enable;
    endproperty
    property p_sample_len;
        $rose(sample_hold) |-> (sample_hold || !front_end_enable) [*6];
    endproperty
    property p_continuous;
        s_convert_start |-> ##[1:60] (sample_hold || !front_end_enable);
    endproperty
    // The first trial after sampling is skipped, since the trial output lags the phase.
    property p_msb_first;
        front_end_enable && !sample_hold && prev_sh == 3'b000 && dac_trial != prev_trial
            && !prev_trial[0] && dac_trial != 10'h000 && prev_trial != 10'h000
            |-> (dac_trial & (~dac_trial + 10'h001)) == (prev_low >> 1);
    endproperty
    property p_low_zero;
        s_read_taken ##0 (s_axi_araddr == {28'h0, ADDR_LOW})
            |-> ##[1:2] (s_axi_rvalid && s_axi_rdata[31:2] == 30'h0);
    endproperty
    property p_unmapped;
        s_read_taken ##0 (s_axi_araddr >= 32'h18)
            |-> ##[1:2] (s_axi_rvalid && s_axi_rresp == AXI_SLVERR && s_axi_rdata == 32'h0);
    endproperty
    property p_read_busy;
        s_axi_rvalid |-> !s_axi_arready;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not clear after reset");
    a_sample_needs_on: assert property (p_sample_needs_on)
        else $error("sampling while converter off");
    a_sample_len: assert property (p_sample_len)
        else $error("sample phase too short");
    a_continuous: assert property (p_continuous)
        else $error("no new conversion after the last one");
    a_msb_first: assert property (p_msb_first)
        else $error("trial bit order wrong");
    a_low_zero: assert property (p_low_zero)
        else $error("low result upper bits not zero");
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not refused");
    a_read_busy: assert property (p_read_busy)
        else $error("read address accepted while data pending");
endmodule

bind sar_adc_control sar_adc_control_checker u_sar_adc_control_checker (
    .aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_bvalid, .front_end_enable, .sample_hold,
    .dac_trial, .irq
);

// File: verification/analog_front_end_model.sv
// Behavioural analog front end: input multiplexer, sample-and-hold and comparator.
`timescale 1ns/1ps
module analog_front_end_model (
    // Clock
    input wire logic aclk,
    // Control from the converter
    input wire logic [3:0] select,
    input wire logic enable,
    input wire logic sample_hold,
    input wire logic [9:0] trial,
    // Input levels; 11'h400 lies above the high reference
    input wire logic [10:0] level [16],
    // Comparator result
    output logic above
);
    logic [10:0] held;
    logic wander = 1'b0;
    always_ff @(posedge aclk) begin
        if (sample_hold) begin
            held <= level[select];
        end
        wander <= ~wander;
    end
    // An idle comparator gives no meaningful answer, so it wanders rather than hold.
    assign above = (enable && !sample_hold) ? (held >= {1'b0, trial}) : wander;
endmodule

// File: verification/sar_adc_control_test.sv
// Register-level testbench of the converter control with a front end model.
`timescale 1ns/1ps
module sar_adc_control_test;
    import sar_adc_pkg::*;
    logic aclk = 1'b0;
    logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb, analog_input_pin_select;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic front_end_enable, sample_hold, comparator_above, irq;
    logic [9:0] dac_trial, want;
    logic [15:0] analog_input_pin, analog_input_pin_level;
    logic [10:0] lvl [16];
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    always #2.5 aclk = ~aclk;
    sar_adc_control u_sar_adc_control (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .analog_input_pin_select,
        .front_end_enable, .sample_hold, .dac_trial, .comparator_above,
        .analog_input_pin, .analog_input_pin_level, .irq
    );
    analog_front_end_model u_analog_front_end_model (
        .aclk, .select(analog_input_pin_select), .enable(front_end_enable), .sample_hold,
        .trial(dac_trial), .level(lvl), .above(comparator_above)
    );
    task automatic stop_test();
        if (err_total == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Ready signals stay high throughout, so a response is taken the edge it shows.
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    task automatic wait_eoc();
        do axi_read(32'(ADDR_CSR), rd, rs); while (rd[CSR_EOC] !== 1'b1);
    endtask
    task automatic read_result(input int ch);
        want = (lvl[ch] >= 11'h400) ? 10'h3ff : lvl[ch][9:0];
        axi_read(32'(ADDR_LOW), rd, rs);
        check(rd, {30'h0, want[1:0]});
        axi_read(32'(ADDR_HIGH), rd, rs);
        check(rd, {24'h0, want[9:2]});
    endtask
    task automatic chk_irq(input logic e);
        repeat (2) @(posedge aclk);
        check(32'(irq), 32'(e));
    endtask
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            stop_test();
        end
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
        {s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        analog_input_pin = 16'h0000;
        for (int k = 0; k < 16; k++) lvl[k] = 11'(k * 67);
        lvl[15] = 11'h400;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            axi_read(32'(4 * k), rd, rs);
            check(rd, 32'h0);
        end
        axi_read(32'h18, rd, rs);
        check(32'(rs), 32'(AXI_SLVERR));
        axi_write(32'h1c, 32'h1, rs);
        check(32'(rs), 32'(AXI_SLVERR));
        analog_input_pin <= 16'ha5c3;
        repeat (3) @(posedge aclk);
        check(32'(analog_input_pin_level), 32'ha5c3);
        // Odd channels run at the fast converter clock, even ones at the slow one.
        for (int k = 0; k < 16; k++) begin
            axi_write(32'(ADDR_CSR), {25'h0, k[0], 2'b10, k[3:0]}, rs);
            wait_eoc();
            check(rd, {24'h0, 1'b1, k[0], 2'b10, k[3:0]});
            read_result(k);
            axi_read(32'(ADDR_CSR), rd, rs);
            check(32'(rd[CSR_EOC]), 32'h0);
        end
        lvl[15] <= 11'h155;
        @(posedge sample_hold);
        @(posedge sample_hold);
        repeat (2) @(posedge aclk);
        read_result(15);
        axi_write(32'(ADDR_IRQ_CLEAR), 32'h3, rs);
        @(negedge sample_hold);
        @(posedge aclk);
        axi_write(32'(ADDR_CSR), 32'h62, rs);
        axi_read(32'(ADDR_CSR), rd, rs);
        check(rd, 32'h62);
        axi_read(32'(ADDR_IRQ_STATUS), rd, rs);
        check(rd & 32'h2, 32'h2);
        wait_eoc();
        read_result(2);
        wait_eoc();
        axi_read(32'(ADDR_HIGH), rd, rs);
        check(rd, {24'h0, lvl[2][9:2]});
        axi_read(32'(ADDR_CSR), rd, rs);
        check(32'(rd[CSR_EOC]), 32'h0);
        axi_write(32'(ADDR_IRQ_ENABLE), 32'h2, rs);
        chk_irq(1'b1);
        axi_write(32'(ADDR_IRQ_ENABLE), 32'h0, rs);
        chk_irq(1'b0);
        axi_write(32'(ADDR_IRQ_ENABLE), 32'h2, rs);
        axi_write(32'(ADDR_IRQ_CLEAR), 32'h2, rs);
        chk_irq(1'b0);
        axi_write(32'(ADDR_CSR), 32'h02, rs);
        repeat (2) @(posedge aclk);
        check(32'({front_end_enable, sample_hold}), 32'h0);
        repeat (100) @(posedge aclk);
        axi_read(32'(ADDR_CSR), rd, rs);
        check(rd, 32'h02);
        stop_test();
    end
endmodule
